// ---- hw/pcsm_cam_check.sv ----
// cam zone tracking, forward sequence, upstroke pulse and mismatch checks
`timescale 1ns/10ps
`default_nettype none
module pcsm_cam_check
	import pcsm_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [2:0] cam_a_i,
	input wire logic [2:0] cam_b_i,
	output pcsm_zone_t zone_o,
	output logic illegal_o,
	output logic from_top_o,
	output logic from_down_o,
	output logic from_up_o,
	output logic upcam_miss_o,
	output logic [2:0] mismatch_o
);
	pcsm_zone_t zone_now;
	pcsm_zone_t zone_reg;
	logic change;
	logic up_on_reg;
	logic up_cycled_reg;

	// zone from cam reading A; the last valid zone is held across bad codes
	assign zone_now = pcsm_zone_decode(cam_a_i);
	assign illegal_o = (zone_now == PCSM_ZONE_BAD);
	assign change = !illegal_o && (zone_now != zone_reg);
	assign zone_o = zone_reg;

	// each zone may only be followed by the next one in order
	assign from_top_o = change && zone_reg == PCSM_ZONE_TOP
		&& zone_now != PCSM_ZONE_DOWN;
	assign from_down_o = change && zone_reg == PCSM_ZONE_DOWN
		&& zone_now != PCSM_ZONE_UP;
	assign from_up_o = change && zone_reg == PCSM_ZONE_UP
		&& zone_now != PCSM_ZONE_TOP;
	assign upcam_miss_o = change && zone_reg == PCSM_ZONE_UP
		&& !up_cycled_reg;

	// redundant readings must agree bit for bit
	assign mismatch_o = cam_a_i ^ cam_b_i;

	// press assumed parked at top after reset
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			zone_reg <= PCSM_ZONE_TOP;
		end else if (change) begin
			zone_reg <= zone_now;
		end
	end

	// upstroke cam must go on and then off inside the upstroke zone
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			up_on_reg <= 1'h0;
			up_cycled_reg <= 1'h0;
		end else if (zone_reg != PCSM_ZONE_UP) begin
			up_on_reg <= 1'h0;
			up_cycled_reg <= 1'h0;
		end else if (cam_a_i[CAM_UP]) begin
			up_on_reg <= 1'h1;
		end else if (up_on_reg) begin
			up_cycled_reg <= 1'h1;
		end
	end
endmodule
`default_nettype wire

// ---- hw/pcsm_debounce.sv ----
// two-flop synchroniser and stability filter for a vector of switch pins
`timescale 1ns/10ps
`default_nettype none
module pcsm_debounce #(
	parameter int WIDTH = 1,
	parameter int STABLE_CYC = 500000
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	localparam int CW = $clog2(STABLE_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

	logic [WIDTH-1:0] sync1_reg;
	logic [WIDTH-1:0] sync2_reg;

	// first flop feeds only the second flop; runs through reset so the
	// filter starts at the real pin level and no false edge follows
	always_ff @(posedge clock_i) begin
		sync1_reg <= pin_i;
		sync2_reg <= sync1_reg;
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic [CW-1:0] cnt_reg;
			logic out_reg;
			// accept a new level only once it has held steady
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					cnt_reg <= '0;
					out_reg <= sync2_reg[g];
				end else if (sync2_reg[g] == out_reg) begin
					cnt_reg <= '0;
				end else if (cnt_reg == LAST) begin
					cnt_reg <= '0;
					out_reg <= sync2_reg[g];
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
			assign level_o[g] = out_reg;
		end
	endgenerate
endmodule
`default_nettype wire

// ---- hw/pcsm_pkg.sv ----
// constants, types and decode helpers for the press cam sequence monitor
package pcsm_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int DEBOUNCE_MS = 5;
	localparam int ARM_TIMEOUT_MS = 5000;
	localparam int MOTION_GRACE_MS = 100;
	localparam int DEBOUNCE_CYC = CYC_PER_MS * DEBOUNCE_MS;
	localparam int ARM_TIMEOUT_CYC = CYC_PER_MS * ARM_TIMEOUT_MS;
	localparam int MOTION_GRACE_CYC = CYC_PER_MS * MOTION_GRACE_MS;

	// ****************************************************************
	// input vector layout (cam bits: upstroke, brake, top)
	// ****************************************************************
	localparam int CAM_UP = 0;
	localparam int CAM_BRK = 1;
	localparam int CAM_TOP = 2;
	localparam int IN_CAM_A = 0;
	localparam int IN_CAM_B = 3;
	localparam int IN_RUN_L = 6;
	localparam int IN_RUN_R = 7;
	localparam int IN_STOP_TOP = 8;
	localparam int IN_ARM = 9;
	localparam int IN_MODE_INCH = 10;
	localparam int IN_MODE_SINGLE = 11;
	localparam int IN_MODE_CONT = 12;
	localparam int IN_AIR_A = 13;
	localparam int IN_AIR_B = 14;
	localparam int IN_MOTOR_A = 15;
	localparam int IN_MOTOR_B = 16;
	localparam int IN_MOTION = 17;
	localparam int NUM_IN = 18;

	// ****************************************************************
	// latched fault bits and their message codes
	// ****************************************************************
	localparam int FLT_ILLEGAL = 0;
	localparam int FLT_FROM_TOP = 1;
	localparam int FLT_FROM_DOWN = 2;
	localparam int FLT_FROM_UP = 3;
	localparam int FLT_FWD_ANY = 4;
	localparam int FLT_UPCAM = 5;
	localparam int FLT_MIS_BRK = 6;
	localparam int FLT_MIS_TOP = 7;
	localparam int FLT_MIS_UP = 8;
	localparam int FLT_MIS_ANY = 9;
	localparam int FLT_BRAKE_MON = 10;
	localparam int NUM_FAULTS = 11;
	localparam logic [7:0] FAULT_CODE [NUM_FAULTS] = '{
		8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h21, 8'h22,
		8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2E};

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FAULT = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTRL_FAULT_RESET = 0;
	localparam int CTRL_RUN_ENABLE = 1;
	localparam logic CTRL_RUN_ENABLE_RST = 1'h0;
	localparam int FAULT_CODE_LSB = 16;
	localparam int STAT_ZONE_LSB = 0;
	localparam int STAT_STATE_LSB = 4;
	localparam int STAT_INTERLOCK = 8;
	localparam int STAT_MOTION_TRIP = 9;
	localparam int STAT_ARM_TIMEOUT = 10;
	localparam int STAT_STOP_REQ = 11;
	localparam int STAT_VALVE = 12;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {PCSM_ZONE_TOP, PCSM_ZONE_DOWN, PCSM_ZONE_UP,
		PCSM_ZONE_BAD} pcsm_zone_t;
	typedef enum logic [2:0] {PCSM_IDLE, PCSM_INCH, PCSM_SS_HOLD,
		PCSM_SS_FINISH, PCSM_ARMED, PCSM_CONT_HOLD,
		PCSM_CONT_RUN} pcsm_state_t;

	// top alone, brake alone, or neither (upstroke cam may pulse)
	function automatic pcsm_zone_t pcsm_zone_decode(input logic [2:0] cam);
		pcsm_zone_t z;
		z = PCSM_ZONE_BAD;
		if (cam == 3'h4) begin
			z = PCSM_ZONE_TOP;
		end else if (cam == 3'h2) begin
			z = PCSM_ZONE_DOWN;
		end else if (cam[CAM_TOP:CAM_BRK] == 2'h0) begin
			z = PCSM_ZONE_UP;
		end
		return z;
	endfunction

endpackage

// ---- hw/pcsm_top.sv ----
// press cam sequence monitor: faults, run modes and register slave
`timescale 1ns/10ps
`default_nettype none
module pcsm_top
	import pcsm_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
	parameter int ARM_CYCLES = ARM_TIMEOUT_CYC,
	parameter int GRACE_CYCLES = MOTION_GRACE_CYC
) (
	input wire logic clock_i,
	input wire logic rst_i,
	// field switches, two readings per cam
	input wire logic upstroke_cam_switch_a_i,
	input wire logic brake_cam_switch_a_i,
	input wire logic top_cam_switch_a_i,
	input wire logic upstroke_cam_switch_b_i,
	input wire logic brake_cam_switch_b_i,
	input wire logic top_cam_switch_b_i,
	input wire logic run_left_i,
	input wire logic run_right_i,
	input wire logic stop_on_top_i,
	input wire logic arm_continuous_i,
	input wire logic mode_inch_i,
	input wire logic mode_single_i,
	input wire logic mode_continuous_i,
	input wire logic air_ok_a_i,
	input wire logic air_ok_b_i,
	input wire logic motor_fwd_a_i,
	input wire logic motor_fwd_b_i,
	input wire logic motion_i,
	// press outputs
	output logic press_valve_o,
	output logic fault_active_o,
	output logic [7:0] fault_code_o,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);
	localparam logic [31:0] ARM_LAST = 32'(ARM_CYCLES - 1);
	localparam logic [31:0] GRACE_LAST = 32'(GRACE_CYCLES - 1);

	logic [NUM_IN-1:0] pins;
	logic [NUM_IN-1:0] in;
	pcsm_zone_t zone;
	logic ev_illegal;
	logic ev_from_top;
	logic ev_from_down;
	logic ev_from_up;
	logic ev_upcam;
	logic [2:0] mismatch;
	logic [NUM_FAULTS-1:0] fault_reg;
	logic [NUM_FAULTS-1:0] fault_set;
	logic fault_clear;
	logic fault_any;
	pcsm_state_t state_reg;
	logic run_both;
	logic m_inch;
	logic m_single;
	logic m_cont;
	logic mode_off;
	logic interlock_ok;
	logic start_ok;
	logic run_active;
	logic at_top_stop;
	logic left_top_reg;
	logic need_release_reg;
	logic stop_req_reg;
	logic brake_watch_reg;
	logic arm_prev_reg;
	logic arm_edge;
	logic [31:0] arm_cnt_reg;
	logic arm_timeout_reg;
	logic [31:0] grace_cnt_reg;
	logic motion_trip;
	logic motion_trip_reg;
	logic halt;
	logic run_enable_reg;
	logic fault_reset_reg;
	logic [7:0] fault_code_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic bus_take;

	// ****************************************************************
	// input conditioning
	// ****************************************************************
	assign pins = {motion_i, motor_fwd_b_i, motor_fwd_a_i, air_ok_b_i,
		air_ok_a_i, mode_continuous_i, mode_single_i, mode_inch_i,
		arm_continuous_i, stop_on_top_i, run_right_i, run_left_i,
		top_cam_switch_b_i, brake_cam_switch_b_i, upstroke_cam_switch_b_i,
		top_cam_switch_a_i, brake_cam_switch_a_i, upstroke_cam_switch_a_i};

	pcsm_debounce #(
		.WIDTH(NUM_IN),
		.STABLE_CYC(DEBOUNCE_CYCLES)
	) u_debounce (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(pins),
		.level_o(in)
	);

	pcsm_cam_check u_cam (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.cam_a_i(in[IN_CAM_A +: 3]),
		.cam_b_i(in[IN_CAM_B +: 3]),
		.zone_o(zone),
		.illegal_o(ev_illegal),
		.from_top_o(ev_from_top),
		.from_down_o(ev_from_down),
		.from_up_o(ev_from_up),
		.upcam_miss_o(ev_upcam),
		.mismatch_o(mismatch)
	);

	// ****************************************************************
	// fault latch
	// ****************************************************************
	// combined bits follow their groups, set or latched
	always_comb begin
		fault_set = '0;
		fault_set[FLT_ILLEGAL] = ev_illegal;
		fault_set[FLT_FROM_TOP] = ev_from_top;
		fault_set[FLT_FROM_DOWN] = ev_from_down;
		fault_set[FLT_FROM_UP] = ev_from_up;
		fault_set[FLT_FWD_ANY] = ev_from_top | ev_from_down | ev_from_up
			| (!fault_clear
			&& (|fault_reg[FLT_FROM_UP:FLT_FROM_TOP]));
		fault_set[FLT_UPCAM] = ev_upcam;
		fault_set[FLT_MIS_BRK] = mismatch[CAM_BRK];
		fault_set[FLT_MIS_TOP] = mismatch[CAM_TOP];
		fault_set[FLT_MIS_UP] = mismatch[CAM_UP];
		fault_set[FLT_MIS_ANY] = (|mismatch)
			| (!fault_clear
			&& (|fault_reg[FLT_MIS_UP:FLT_MIS_BRK]));
		fault_set[FLT_BRAKE_MON] = brake_watch_reg
			&& zone == PCSM_ZONE_DOWN;
	end

	// a fault arriving in the clearing cycle still latches
	assign fault_clear = fault_reset_reg | mode_off;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			fault_reg <= '0;
		end else begin
			fault_reg <= (fault_reg & ~{NUM_FAULTS{fault_clear}})
				| fault_set;
		end
	end
	assign fault_any = |fault_reg;

	// lowest numbered active fault is the one shown
	function automatic logic [7:0] first_code(
		input logic [NUM_FAULTS-1:0] f);
		logic [7:0] c;
		c = 8'h00;
		for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
			if (f[i]) begin
				c = FAULT_CODE[i];
			end
		end
		return c;
	endfunction

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			fault_code_reg <= 8'h00;
		end else begin
			fault_code_reg <= first_code(fault_reg);
		end
	end
	assign fault_code_o = fault_code_reg;
	assign fault_active_o = fault_any;

	// ****************************************************************
	// mode and interlock decode
	// ****************************************************************
	// two or more positions at once count as no valid mode
	assign m_inch = in[IN_MODE_INCH] & !in[IN_MODE_SINGLE]
		& !in[IN_MODE_CONT];
	assign m_single = in[IN_MODE_SINGLE] & !in[IN_MODE_INCH]
		& !in[IN_MODE_CONT];
	assign m_cont = in[IN_MODE_CONT] & !in[IN_MODE_INCH]
		& !in[IN_MODE_SINGLE];
	assign mode_off = !(in[IN_MODE_INCH] | in[IN_MODE_SINGLE]
		| in[IN_MODE_CONT]);
	assign run_both = in[IN_RUN_L] & in[IN_RUN_R];
	assign interlock_ok = in[IN_AIR_A] & in[IN_AIR_B]
		& in[IN_MOTOR_A] & in[IN_MOTOR_B]
		& run_enable_reg;
	// a fresh two-hand press is needed after every halt
	assign start_ok = run_both & !need_release_reg & interlock_ok
		& !fault_any;
	assign arm_edge = in[IN_ARM] & !arm_prev_reg;
	assign at_top_stop = (zone == PCSM_ZONE_TOP) && left_top_reg;
	assign run_active = state_reg == PCSM_INCH
		|| state_reg == PCSM_SS_HOLD || state_reg == PCSM_SS_FINISH
		|| state_reg == PCSM_CONT_HOLD || state_reg == PCSM_CONT_RUN;
	assign motion_trip = run_active && grace_cnt_reg == GRACE_LAST
		&& !in[IN_MOTION];
	assign halt = fault_any | motion_trip;
	assign press_valve_o = run_active && !halt;

	// ****************************************************************
	// run state machine
	// ****************************************************************
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg <= PCSM_IDLE;
		end else if (halt) begin
			state_reg <= PCSM_IDLE;
		end else begin
			unique case (state_reg)
				PCSM_IDLE: begin
					if (m_inch && start_ok) begin
						state_reg <= PCSM_INCH;
					end else if (m_single && start_ok) begin
						state_reg <= PCSM_SS_HOLD;
					end else if (m_cont && arm_edge && interlock_ok) begin
						state_reg <= PCSM_ARMED;
					end
				end
				PCSM_INCH: begin
					if (!run_both || at_top_stop || !m_inch) begin
						state_reg <= PCSM_IDLE;
					end
				end
				PCSM_SS_HOLD: begin
					if (!run_both || !m_single) begin
						state_reg <= PCSM_IDLE;
					end else if (zone == PCSM_ZONE_UP) begin
						state_reg <= PCSM_SS_FINISH;
					end
				end
				PCSM_SS_FINISH: begin
					if (at_top_stop || !m_single) begin
						state_reg <= PCSM_IDLE;
					end
				end
				PCSM_ARMED: begin
					if (!m_cont || arm_cnt_reg == ARM_LAST) begin
						state_reg <= PCSM_IDLE;
					end else if (start_ok) begin
						state_reg <= PCSM_CONT_HOLD;
					end
				end
				PCSM_CONT_HOLD: begin
					if (!run_both || !m_cont) begin
						state_reg <= PCSM_IDLE;
					end else if (zone == PCSM_ZONE_UP) begin
						state_reg <= PCSM_CONT_RUN;
					end
				end
				PCSM_CONT_RUN: begin
					if (!m_cont || (stop_req_reg && at_top_stop)) begin
						state_reg <= PCSM_IDLE;
					end
				end
			endcase
		end
	end

	// stroke bookkeeping: has the slide left top since the stroke began
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			left_top_reg <= 1'h0;
		end else if (!run_active) begin
			left_top_reg <= 1'h0;
		end else if (zone != PCSM_ZONE_TOP) begin
			left_top_reg <= 1'h1;
		end else if (state_reg == PCSM_CONT_RUN) begin
			left_top_reg <= 1'h0;
		end
	end

	// buttons must be let go before another start
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			need_release_reg <= 1'h1;
		end else if (run_active) begin
			need_release_reg <= 1'h1;
		end else if (!in[IN_RUN_L] && !in[IN_RUN_R]) begin
			need_release_reg <= 1'h0;
		end
	end

	// stop-on-top request held until the cycle ends
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stop_req_reg <= 1'h0;
		end else if (!run_active) begin
			stop_req_reg <= 1'h0;
		end else if (m_cont && in[IN_STOP_TOP]) begin
			stop_req_reg <= 1'h1;
		end
	end

	// after a stop at top, watch for overtravel until motion ceases
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			brake_watch_reg <= 1'h0;
		end else if (run_active && at_top_stop) begin
			brake_watch_reg <= 1'h1;
		end else if (run_active || !in[IN_MOTION]) begin
			brake_watch_reg <= 1'h0;
		end
	end

	// ****************************************************************
	// timers
	// ****************************************************************
	// arm window runs only while armed
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			arm_prev_reg <= 1'h0;
			arm_cnt_reg <= '0;
			arm_timeout_reg <= 1'h0;
		end else begin
			arm_prev_reg <= in[IN_ARM];
			if (state_reg != PCSM_ARMED) begin
				arm_cnt_reg <= '0;
			end else begin
				arm_cnt_reg <= arm_cnt_reg + 32'h1;
			end
			if (state_reg == PCSM_ARMED && arm_cnt_reg == ARM_LAST) begin
				arm_timeout_reg <= 1'h1;
			end else if (run_active) begin
				arm_timeout_reg <= 1'h0;
			end
		end
	end

	// motion must appear within the grace time, well before bottom
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			grace_cnt_reg <= '0;
			motion_trip_reg <= 1'h0;
		end else begin
			if (!run_active) begin
				grace_cnt_reg <= '0;
			end else if (grace_cnt_reg != GRACE_LAST) begin
				grace_cnt_reg <= grace_cnt_reg + 32'h1;
			end
			if (motion_trip) begin
				motion_trip_reg <= 1'h1;
			end else if (run_active) begin
				motion_trip_reg <= 1'h0;
			end
		end
	end

	// ****************************************************************
	// AHB-Lite slave, zero wait states, always OKAY
	// ****************************************************************
	assign hreadyout_o = 1'h1;
	assign hresp_o = 1'h0;
	assign hrdata_o = hrdata_reg;
	assign bus_take = hsel_i && htrans_i[1] && hready_i;

	// read data is captured in the address phase so it stands in the data
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (bus_take && !hwrite_i) begin
			hrdata_reg <= 32'h0000_0000;
			unique case (haddr_i[7:0])
				REG_CTRL: begin
					hrdata_reg[CTRL_RUN_ENABLE] <= run_enable_reg;
				end
				REG_FAULT: begin
					hrdata_reg[NUM_FAULTS-1:0] <= fault_reg;
					hrdata_reg[FAULT_CODE_LSB +: 8] <= fault_code_reg;
				end
				REG_STATUS: begin
					hrdata_reg[STAT_ZONE_LSB +: 2] <= zone;
					hrdata_reg[STAT_STATE_LSB +: 3] <= state_reg;
					hrdata_reg[STAT_INTERLOCK] <= interlock_ok;
					hrdata_reg[STAT_MOTION_TRIP] <= motion_trip_reg;
					hrdata_reg[STAT_ARM_TIMEOUT] <= arm_timeout_reg;
					hrdata_reg[STAT_STOP_REQ] <= stop_req_reg;
					hrdata_reg[STAT_VALVE] <= press_valve_o;
				end
				default: begin
					hrdata_reg <= 32'h0000_0000;
				end
			endcase
		end
	end

	// writes land in the data phase; fault reset is a one-cycle pulse
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wr_pend_reg <= 1'h0;
			wr_addr_reg <= 8'h00;
			run_enable_reg <= CTRL_RUN_ENABLE_RST;
			fault_reset_reg <= 1'h0;
		end else begin
			wr_pend_reg <= bus_take && hwrite_i;
			wr_addr_reg <= haddr_i[7:0];
			fault_reset_reg <= 1'h0;
			if (wr_pend_reg && wr_addr_reg == REG_CTRL) begin
				run_enable_reg <= hwdata_i[CTRL_RUN_ENABLE];
				fault_reset_reg <= hwdata_i[CTRL_FAULT_RESET];
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/pcsm_assertions.sv ----
// port checker for the press cam sequence monitor
`timescale 1ns/10ps
`default_nettype none
module pcsm_checker (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic air_ok_a_i,
	input wire logic air_ok_b_i,
	input wire logic motor_fwd_a_i,
	input wire logic motor_fwd_b_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic press_valve_o,
	input wire logic fault_active_o,
	input wire logic [7:0] fault_code_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic rd;
	// read address phase taken this edge
	assign rd = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
	// ****
	// assertions
	// ****
	bus_ready_a: assert property (hreadyout_o)
		else $error("hready low");
	bus_okay_a: assert property (!hresp_o)
		else $error("error response");
	valve_off_a: assert property (fault_active_o |-> !press_valve_o)
		else $error("valve on with fault");
	code_set_a: assert property (fault_active_o |=> fault_code_o != 8'h00)
		else $error("fault without code");
	code_clear_a: assert property (!fault_active_o |=> fault_code_o == 8'h00)
		else $error("code without fault");
	code_legal_a: assert property (fault_code_o != 8'h00 |-> fault_code_o inside
		{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h21, 8'h22, 8'h29, 8'h2A, 8'h2B, 8'h2C,
		8'h2E}) else $error("unknown code");
	start_lock_a: assert property ($rose(press_valve_o) |-> air_ok_a_i &&
		air_ok_b_i && motor_fwd_a_i && motor_fwd_b_i)
		else $error("start without interlock");
	unmapped_read_a: assert property (rd && haddr_i[7:2] > 6'h02 |=>
		hrdata_o == 32'h0) else $error("unmapped read nonzero");
	rdata_hold_a: assert property (!rd |=> $stable(hrdata_o))
		else $error("read data moved");
	cover property ($rose(press_valve_o));
	cover property ($rose(fault_active_o));
	cover property ($fell(fault_active_o));
endmodule
bind pcsm_top pcsm_checker chk (.clock_i, .rst_i, .air_ok_a_i, .air_ok_b_i,
	.motor_fwd_a_i, .motor_fwd_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
	.hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .press_valve_o,
	.fault_active_o, .fault_code_o);
`default_nettype wire

// ---- tb/pcsm_field_model.sv ----
// crank and rotary cam set model driven by the press valve
`timescale 1ns/10ps
`default_nettype none
module pcsm_field_model (
	input wire logic clock_i,
	input wire logic valve_i,
	input wire logic [2:0] flip_i,
	input wire logic bad_i,
	input wire logic skip_i,
	output logic [2:0] cam_a_o,
	output logic [2:0] cam_b_o,
	output logic motion_o,
	output logic [5:0] pos_o
);
	logic [5:0] pos_reg = 6'h00;
	logic mov_reg = 1'b0;
	// crank steps once a cycle only while the clutch is in
	always_ff @(posedge clock_i) begin
		if (valve_i) begin
			pos_reg <= pos_reg + 6'h01;
		end
		mov_reg <= valve_i;
	end
	assign motion_o = mov_reg;
	assign pos_o = pos_reg;
	// ****
	// cams {top,brake,up}: top wraps 56..7, down 8..31, up 32..55
	// ****
	always_comb begin
		if (pos_reg < 6'h08 || pos_reg >= 6'h38) begin
			cam_a_o = 3'h4;
		end else if (pos_reg < 6'h20) begin
			cam_a_o = 3'h2;
		end else begin
			cam_a_o = {2'h0, pos_reg[5:3] == 3'h5 && !skip_i};
		end
		if (bad_i) begin
			cam_a_o = 3'h7;
		end
		// second reading differs only where a scenario asks for it
		cam_b_o = cam_a_o ^ flip_i;
	end
endmodule
`default_nettype wire

// ---- tb/press_cam_sequence_monitor_test.sv ----
// self-checking bench for the press cam sequence monitor
`timescale 1ns/10ps
`default_nettype none
module press_cam_sequence_monitor_test
	import pcsm_pkg::*;
;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic run_l = 1'b0, run_r = 1'b0, stop = 1'b0, arm = 1'b0;
	logic bad = 1'b0, skip = 1'b0, mot_en = 1'b1, hsel = 1'b0, hw = 1'b0;
	logic [2:0] mode = 3'h0, flip = 3'h0; // mode {cont,single,inch}
	logic [3:0] ilk = 4'hF; // {motor_b,motor_a,air_b,air_a}
	logic [1:0] htr = 2'h0;
	logic [31:0] haddr = 32'h0, hwd = 32'h0, q, hrd;
	logic [2:0] ca, cb;
	logic motion, valve, fact, hrdy, hresp;
	logic [5:0] pos;
	logic [7:0] code;
	int bad_count = 0, n_tests = 0, cyc = 0;
	pcsm_field_model fm (.clock_i, .valve_i(valve), .flip_i(flip),
		.bad_i(bad), .skip_i(skip), .cam_a_o(ca), .cam_b_o(cb),
		.motion_o(motion), .pos_o(pos));
	pcsm_top #(.DEBOUNCE_CYCLES(4), .ARM_CYCLES(200), .GRACE_CYCLES(10)) uut (
		.clock_i, .rst_i, .upstroke_cam_switch_a_i(ca[0]),
		.brake_cam_switch_a_i(ca[1]), .top_cam_switch_a_i(ca[2]),
		.upstroke_cam_switch_b_i(cb[0]), .brake_cam_switch_b_i(cb[1]),
		.top_cam_switch_b_i(cb[2]), .run_left_i(run_l), .run_right_i(run_r),
		.stop_on_top_i(stop), .arm_continuous_i(arm), .mode_inch_i(mode[0]),
		.mode_single_i(mode[1]), .mode_continuous_i(mode[2]),
		.air_ok_a_i(ilk[0]), .air_ok_b_i(ilk[1]), .motor_fwd_a_i(ilk[2]),
		.motor_fwd_b_i(ilk[3]), .motion_i(motion & mot_en),
		.press_valve_o(valve), .fault_active_o(fact), .fault_code_o(code),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htr), .hwrite_i(hw),
		.hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hrdata_o(hrd),
		.hreadyout_o(hrdy), .hresp_o(hresp));
	initial forever #5 clock_i = ~clock_i;
	// ****
	// shared tasks
	// ****
	task automatic print_verdict();
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// sample at the falling edge so the rising edge updates have landed
	task automatic wv(input logic v);
		for (int i = 0; i < 300 && valve !== v; i++) @(negedge clock_i);
		chk(valve, v);
	endtask
	task automatic btn(input logic v);
		@(posedge clock_i);
		run_l <= v;
		run_r <= v;
	endtask
	task automatic setm(input logic [2:0] m);
		@(posedge clock_i);
		mode <= m;
		tick(10);
	endtask
	function automatic logic top();
		return pos >= 6'h38 || pos < 6'h08;
	endfunction
	// one single transfer; the master waits for hready at each phase
	task automatic ahb(input logic w, input logic [7:0] a, input int d);
		@(posedge clock_i);
		{hsel, htr, hw, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
		do @(posedge clock_i); while (hrdy !== 1'b1);
		{hsel, htr, hwd} <= {1'b0, 2'h0, d};
		do @(posedge clock_i); while (hrdy !== 1'b1);
		q = hrd;
	endtask
	// ****
	// scenarios
	// ****
	task automatic s_single();
		btn(1'b1);
		wv(1'b1);
		wv(1'b0);
		chk(top(), 1'b1);
		tick(100);
		@(negedge clock_i);
		chk(valve, 1'b0);
		btn(1'b0);
		tick(8);
		btn(1'b1);
		wv(1'b1);
		tick(12);
		btn(1'b0);
		tick(8);
		@(negedge clock_i);
		chk(valve, 1'b0);
		chk(pos < 6'h20, 1'b1);
		btn(1'b1);
		wv(1'b1);
		while (pos < 6'h24) tick(1);
		btn(1'b0);
		wv(1'b0);
		chk(top(), 1'b1);
	endtask
	task automatic s_inch();
		setm(3'h1);
		btn(1'b1);
		wv(1'b1);
		tick(10);
		run_l <= 1'b0;
		tick(8);
		@(negedge clock_i);
		chk(valve, 1'b0);
		btn(1'b0);
		tick(8);
		btn(1'b1);
		wv(1'b1);
		wv(1'b0);
		chk(top(), 1'b1);
		btn(1'b0);
	endtask
	task automatic s_cont();
		setm(3'h4);
		arm <= 1'b1;
		tick(8);
		arm <= 1'b0;
		btn(1'b1);
		wv(1'b1);
		while (pos < 6'h28) tick(1);
		btn(1'b0);
		tick(150);
		@(negedge clock_i);
		chk(valve, 1'b1);
		tick(1);
		stop <= 1'b1;
		tick(8);
		stop <= 1'b0;
		wv(1'b0);
		chk(top(), 1'b1);
		tick(1);
		arm <= 1'b1;
		tick(8);
		arm <= 1'b0;
		tick(250);
		btn(1'b1);
		tick(20);
		@(negedge clock_i);
		chk(valve, 1'b0);
		btn(1'b0);
	endtask
	task automatic s_lock();
		setm(3'h2);
		for (int k = 0; k < 4; k++) begin
			ilk <= 4'hF ^ (4'h1 << k);
			tick(8);
			btn(1'b1);
			tick(20);
			@(negedge clock_i);
			chk(valve, 1'b0);
			btn(1'b0);
			ilk <= 4'hF;
			tick(10);
		end
		mot_en <= 1'b0;
		btn(1'b1);
		wv(1'b1);
		wv(1'b0);
		chk(pos < 6'h20, 1'b1);
		btn(1'b0);
		mot_en <= 1'b1;
		tick(8);
		btn(1'b1);
		wv(1'b1);
		wv(1'b0);
		btn(1'b0);
	endtask
	task automatic s_fault();
		logic [7:0] ec [5] = '{8'h1A, 8'h29, 8'h2A, 8'h2B, 8'h22};
		logic [2:0] fl [5] = '{3'h0, 3'h2, 3'h4, 3'h1, 3'h0};
		for (int k = 0; k < 5; k++) begin
			tick(1);
			{flip, bad, skip} <= {fl[k], k == 0, k == 4};
			if (k == 4) btn(1'b1);
			tick(10);
			wv(1'b0);
			chk(fact, 1'b1);
			@(negedge clock_i); // code lags the latch
			chk(code, ec[k]);
			btn(1'b0);
			{flip, bad, skip} <= 5'h00;
			tick(20);
			ahb(1'b0, REG_FAULT, 0);
			chk(q[23:16], ec[k]);
			chk(q[9], k inside {[1:3]});
			if (k < 4) ahb(1'b1, REG_CTRL, 32'h3);
			else setm(3'h0);
			tick(4);
			@(negedge clock_i);
			chk(fact, 1'b0);
		end
	endtask
	// watchdog: the whole run needs well under this many cycles
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		tick(4);
		rst_i <= 1'b0;
		ahb(1'b0, REG_CTRL, 0);
		chk(q, 32'h0);
		ahb(1'b1, REG_CTRL, 32'h2);
		ahb(1'b0, REG_CTRL, 0);
		chk(q, 32'h2);
		ahb(1'b0, 8'h0C, 0);
		chk(q, 32'h0);
		setm(3'h2);
		s_single();
		s_inch();
		s_cont();
		s_lock();
		s_fault();
		print_verdict();
	end
endmodule
`default_nettype wire
